// ### verilog/serial_pkg.sv
// package for the asynchronous serial slice: register map, field positions,
// reset values, baud and infrared timing, bus carriers.
// assumes a 125 MHz module clock and an AXI4-Lite master with 8-bit addresses.
package serial_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [2:0] IDX_BAUD_HIGH = 3'h0;
  localparam logic [2:0] IDX_BAUD_LOW = 3'h1;
  localparam logic [2:0] IDX_CONTROL = 3'h2;
  localparam logic [2:0] IDX_STATUS_ONE = 3'h4;
  localparam logic [2:0] IDX_STATUS_TWO = 3'h5;
  localparam logic [2:0] IDX_DATA_HIGH = 3'h6;
  localparam logic [2:0] IDX_DATA_LOW = 3'h7;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int RX_NINTH_POS = 7;
  localparam int TX_NINTH_POS = 6;
  localparam int TX_POL_POS = 4;
  localparam int RX_POL_POS = 3;
  localparam int CTL_NINE_POS = 0;
  localparam int CTL_PAR_EN_POS = 1;
  localparam int CTL_PAR_ODD_POS = 2;
  localparam int CTL_IR_EN_POS = 3;
  localparam int CTL_PW_POS = 4;

  // ----------------------------------------------------------------------
  // reset values and responses
  // ----------------------------------------------------------------------
  localparam logic [12:0] DIV_RESET = 13'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // baud and infrared timing
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam longint IR_MAX_BPS = 115200;
  localparam longint IR_MIN_BPS = 2400;
  localparam logic [12:0] IR_DIV_MIN = 13'(CLK_HZ / (16 * IR_MAX_BPS));
  localparam logic [12:0] IR_DIV_MAX = 13'(CLK_HZ / (16 * IR_MIN_BPS));
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [4:0] STRETCH_LEN = 5'h10;
  localparam logic [4:0] PULSE_CENTRE = 5'h10;

  typedef enum logic [1:0] {PW_1_32, PW_1_16, PW_3_16, PW_1_4} pulse_width_t;

  // ----------------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

endpackage : serial_pkg

// ### verilog/serial_unit.sv
// serial unit: data register pair, infrared encoder/decoder, frame engine,
// 13-bit baud generator, AXI4-Lite register slave.
// assumes RXD is already synchronous to CLK and one master on the bus.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps

// Operation
// - nine-bit mode: received ninth bit appears at data high bit 7
// - nine-bit mode: data high bit 6 is sent as ninth data bit
// - reading data low returns receive buffer; writing loads transmit buffer
// - writes to the received ninth bit position are ignored
// - transmit ninth bit persists and is reused until rewritten
// - eight-bit characters need only the data low register
// - transmitter and receiver run independently from one baud generator
// - infrared: centred narrow pulse per zero bit, four selectable widths
// - transmit polarity picks high-going or low-going infrared pulse
// - receive polarity picks which narrow pulse level means zero
// - sixteen and thirty-two times baud enables time transmit pulses
// - infrared decoder uses only x16 enable and stretches pulses
// - infrared works only between 2.4 and 115.2 kbit/s
// - NRZ without infrared, return-to-zero-inverted with infrared
// - frame is start, eight or nine data bits, one stop bit
// - one data position may carry an address mark bit
// - baud generator is a 13-bit modulus counter, divisor 0 to 8191
// - receiver samples sixteen times per bit, transmitter at x16 over sixteen
// - line rate is module clock over sixteen times divisor
// - with parity enabled the data MSB carries parity
// - baud generator halts while divisor is zero
// - transmit polarity status two bit 4, receive polarity bit 3
module serial_unit
  import serial_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire axi_req_t AXI_REQ,
  output axi_rsp_t AXI_RSP,
  input wire logic RXD,
  output logic TXD
);

  typedef enum logic [1:0] {T_IDLE, T_START, T_DATA, T_STOP} tx_state_t;
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} rx_state_t;

  typedef struct packed {
    logic [12:0] div;
    logic [4:0] div_hi;
    logic [12:0] cnt;
    logic half;
    logic nine;
    logic par_en;
    logic par_odd;
    logic ir_en;
    pulse_width_t pw;
    logic tx_pol;
    logic rx_pol;
    logic [7:0] tx_buf;
    logic tx_ninth;
    logic tx_pend;
    tx_state_t tx_st;
    logic [8:0] tx_sh;
    logic [3:0] tx_bits;
    logic [3:0] tx_ph;
    logic txd;
    logic [7:0] rx_buf;
    logic rx_ninth;
    logic rx_full;
    logic rx_pe;
    logic rx_fe;
    rx_state_t rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_bits;
    logic [3:0] rx_ph;
    logic [4:0] stretch;
    logic aw_have;
    logic [2:0] aw_idx;
    logic aw_ok;
    logic w_have;
    logic [7:0] wbyte;
    logic wlane;
    axi_rsp_t rsp;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[7:5] == 3'h0) && (a[1:0] == 2'h0) && (a[4:2] != 3'h3);
  endfunction : addr_mapped

  function automatic logic in_pulse(input pulse_width_t w, input logic [4:0] p);
    unique case (w)
      PW_1_32: in_pulse = (p == PULSE_CENTRE);
      PW_1_16: in_pulse = (p >= PULSE_CENTRE - 5'h1) && (p <= PULSE_CENTRE);
      PW_3_16: in_pulse = (p >= PULSE_CENTRE - 5'h3) && (p <= PULSE_CENTRE + 5'h2);
      PW_1_4: in_pulse = (p >= PULSE_CENTRE - 5'h4) && (p <= PULSE_CENTRE + 5'h3);
    endcase
  endfunction : in_pulse

  // ----------------------------------------------------------------------
  // combinational terms shared by the next-state logic
  // ----------------------------------------------------------------------
  logic tick16;
  logic tick32;
  logic ir_on;
  logic rx_line;
  logic wr_fire;
  logic rd_fire;
  logic [2:0] rd_idx;
  logic [3:0] n_data;
  logic tx_bit;
  logic frame_done;

  // one modulus counter feeds both directions; x32 adds a mid-count tick
  always_comb begin
    tick16 = (st_ff.div != 13'h0) && (st_ff.cnt == st_ff.div);
    tick32 = tick16 || ((st_ff.div > 13'h1) && (st_ff.cnt == (st_ff.div >> 1)));
    ir_on = st_ff.ir_en && (st_ff.div >= IR_DIV_MIN) && (st_ff.div <= IR_DIV_MAX);
    rx_line = ir_on ? (st_ff.stretch == 5'h0) : (RXD ^ st_ff.rx_pol);
    n_data = st_ff.nine ? 4'h9 : 4'h8;
    wr_fire = st_ff.aw_have && st_ff.w_have && !st_ff.rsp.bvalid;
    rd_fire = AXI_REQ.arvalid && st_ff.rsp.arready;
    rd_idx = AXI_REQ.araddr[4:2];
    frame_done = tick16 && (st_ff.rx_st == R_STOP) && (st_ff.rx_ph == PHASE_LAST);
    unique case (st_ff.tx_st)
      T_START: tx_bit = 1'b0;
      T_DATA: tx_bit = st_ff.tx_sh[0];
      default: tx_bit = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [8:0] load;
    logic [7:0] rd;
    logic [7:0] rdat;
    logic rninth;
    load = 9'h0;
    rd = 8'h0;
    rdat = 8'h0;
    rninth = 1'b0;
    nxt_st = st_ff;

    // baud counter counts 1..div; divisor zero holds it still
    if (st_ff.div == 13'h0) begin
      nxt_st.cnt = 13'h1;
      nxt_st.half = 1'b0;
    end else begin
      nxt_st.cnt = tick16 ? 13'h1 : st_ff.cnt + 13'h1;
      if (tick16) begin
        nxt_st.half = 1'b0;
      end else if (tick32) begin
        nxt_st.half = 1'b1;
      end
    end

    // transmitter, stepped only by x16 ticks, sixteen per bit
    if (tick16) begin
      nxt_st.tx_ph = st_ff.tx_ph + 4'h1;
      unique case (st_ff.tx_st)
        T_IDLE: begin
          nxt_st.tx_ph = 4'h0;
          if (st_ff.tx_pend) begin
            load = {st_ff.tx_ninth, st_ff.tx_buf};
            if (st_ff.par_en && st_ff.nine) begin
              load[8] = (^load[7:0]) ^ st_ff.par_odd;
            end else if (st_ff.par_en) begin
              load[7] = (^load[6:0]) ^ st_ff.par_odd;
            end
            nxt_st.tx_sh = load;
            nxt_st.tx_pend = 1'b0;
            nxt_st.tx_st = T_START;
          end
        end
        T_START: begin
          if (st_ff.tx_ph == PHASE_LAST) begin
            nxt_st.tx_st = T_DATA;
            nxt_st.tx_bits = 4'h0;
          end
        end
        T_DATA: begin
          if (st_ff.tx_ph == PHASE_LAST) begin
            nxt_st.tx_sh = {1'b0, st_ff.tx_sh[8:1]};
            nxt_st.tx_bits = st_ff.tx_bits + 4'h1;
            if (st_ff.tx_bits == n_data - 4'h1) begin
              nxt_st.tx_st = T_STOP;
            end
          end
        end
        T_STOP: begin
          if (st_ff.tx_ph == PHASE_LAST) begin
            nxt_st.tx_st = T_IDLE;
          end
        end
      endcase
    end

    // line encoder: centred pulse on zero bits in infrared, plain level else
    if (ir_on) begin
      nxt_st.txd = ((!tx_bit) && in_pulse(st_ff.pw, {st_ff.tx_ph, st_ff.half}))
                   ^ st_ff.tx_pol;
    end else begin
      nxt_st.txd = tx_bit ^ st_ff.tx_pol;
    end

    // pulse stretcher: any active level reloads a one-bit-long zero
    if (RXD ^ st_ff.rx_pol) begin
      nxt_st.stretch = STRETCH_LEN;
    end else if (tick16 && st_ff.stretch != 5'h0) begin
      nxt_st.stretch = st_ff.stretch - 5'h1;
    end

    // receiver, sampling the line on every x16 tick
    if (tick16) begin
      nxt_st.rx_ph = st_ff.rx_ph + 4'h1;
      unique case (st_ff.rx_st)
        R_IDLE: begin
          nxt_st.rx_ph = 4'h0;
          if (!rx_line) begin
            nxt_st.rx_st = R_START;
          end
        end
        R_START: begin
          if (st_ff.rx_ph == START_MID) begin
            // a start bit that is gone at mid-bit was a glitch
            nxt_st.rx_st = rx_line ? R_IDLE : R_DATA;
            nxt_st.rx_ph = 4'h0;
            nxt_st.rx_bits = 4'h0;
          end
        end
        R_DATA: begin
          if (st_ff.rx_ph == PHASE_LAST) begin
            nxt_st.rx_sh = {rx_line, st_ff.rx_sh[8:1]};
            nxt_st.rx_bits = st_ff.rx_bits + 4'h1;
            if (st_ff.rx_bits == n_data - 4'h1) begin
              nxt_st.rx_st = R_STOP;
            end
          end
        end
        R_STOP: begin
          if (st_ff.rx_ph == PHASE_LAST) begin
            nxt_st.rx_st = R_IDLE;
          end
        end
      endcase
    end

    // read side effect first, so a frame landing the same cycle wins
    if (rd_fire && addr_mapped(AXI_REQ.araddr) && rd_idx == IDX_DATA_LOW) begin
      nxt_st.rx_full = 1'b0;
    end
    if (frame_done && !nxt_st.rx_full) begin
      rdat = st_ff.nine ? st_ff.rx_sh[7:0] : st_ff.rx_sh[8:1];
      rninth = st_ff.nine && st_ff.rx_sh[8];
      nxt_st.rx_buf = rdat;
      nxt_st.rx_ninth = rninth;
      nxt_st.rx_full = 1'b1;
      nxt_st.rx_fe = !rx_line;
      nxt_st.rx_pe = st_ff.par_en && (((^rdat) ^ rninth) != st_ff.par_odd);
    end

    // write channels are taken independently, then applied together
    if (AXI_REQ.awvalid && st_ff.rsp.awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_idx = AXI_REQ.awaddr[4:2];
      nxt_st.aw_ok = addr_mapped(AXI_REQ.awaddr);
    end
    if (AXI_REQ.wvalid && st_ff.rsp.wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wbyte = AXI_REQ.wdata[7:0];
      nxt_st.wlane = AXI_REQ.wstrb[0];
    end
    if (wr_fire) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.rsp.bresp = st_ff.aw_ok ? RESP_OKAY : RESP_SLVERR;
      if (st_ff.aw_ok && st_ff.wlane) begin
        unique case (st_ff.aw_idx)
          IDX_BAUD_HIGH: nxt_st.div_hi = st_ff.wbyte[4:0];
          // the high half only takes effect with the low write
          IDX_BAUD_LOW: nxt_st.div = {st_ff.div_hi, st_ff.wbyte};
          IDX_CONTROL: begin
            nxt_st.nine = st_ff.wbyte[CTL_NINE_POS];
            nxt_st.par_en = st_ff.wbyte[CTL_PAR_EN_POS];
            nxt_st.par_odd = st_ff.wbyte[CTL_PAR_ODD_POS];
            nxt_st.ir_en = st_ff.wbyte[CTL_IR_EN_POS];
            nxt_st.pw = pulse_width_t'(st_ff.wbyte[CTL_PW_POS +: 2]);
          end
          IDX_STATUS_TWO: begin
            nxt_st.tx_pol = st_ff.wbyte[TX_POL_POS];
            nxt_st.rx_pol = st_ff.wbyte[RX_POL_POS];
          end
          // received ninth bit is not writable here
          IDX_DATA_HIGH: nxt_st.tx_ninth = st_ff.wbyte[TX_NINTH_POS];
          IDX_DATA_LOW: begin
            nxt_st.tx_buf = st_ff.wbyte;
            nxt_st.tx_pend = 1'b1;
          end
          default: ;
        endcase
      end
    end
    if (st_ff.rsp.bvalid && AXI_REQ.bready) begin
      nxt_st.rsp.bvalid = 1'b0;
    end
    nxt_st.rsp.awready = !nxt_st.aw_have && !nxt_st.rsp.bvalid;
    nxt_st.rsp.wready = !nxt_st.w_have && !nxt_st.rsp.bvalid;

    // read answer one cycle after address acceptance
    if (rd_fire) begin
      unique case (rd_idx)
        IDX_BAUD_HIGH: rd = {3'h0, st_ff.div[12:8]};
        IDX_BAUD_LOW: rd = st_ff.div[7:0];
        IDX_CONTROL: rd = {2'h0, st_ff.pw, st_ff.ir_en, st_ff.par_odd, st_ff.par_en,
                           st_ff.nine};
        IDX_STATUS_ONE: rd = {4'h0, st_ff.rx_fe, st_ff.rx_pe, !st_ff.tx_pend,
                              st_ff.rx_full};
        IDX_STATUS_TWO: rd = {3'h0, st_ff.tx_pol, st_ff.rx_pol, 2'h0,
                              st_ff.rx_st != R_IDLE};
        IDX_DATA_HIGH: rd = {st_ff.rx_ninth, st_ff.tx_ninth, 6'h0};
        IDX_DATA_LOW: rd = st_ff.rx_buf;
        default: rd = 8'h0;
      endcase
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata = addr_mapped(AXI_REQ.araddr) ? {24'h0, rd} : 32'h0;
      nxt_st.rsp.rresp = addr_mapped(AXI_REQ.araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_ff.rsp.rvalid && AXI_REQ.rready) begin
      nxt_st.rsp.rvalid = 1'b0;
    end
    nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_ff <= '0;
      st_ff.div <= DIV_RESET;
      st_ff.cnt <= 13'h1;
      st_ff.txd <= 1'b1;
      st_ff.rsp.awready <= 1'b1;
      st_ff.rsp.wready <= 1'b1;
      st_ff.rsp.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign AXI_RSP = st_ff.rsp;
  assign TXD = st_ff.txd;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_baud_halt_zero: assert property (@(posedge CLK) disable iff (SRST)
    (st_ff.div == 13'h0 && !wr_fire) |=> ($stable(st_ff.tx_st) && $stable(st_ff.rx_st)))
    else $error("serial engines moved with zero divisor");
  a_baud_period_two: assert property (@(posedge CLK) disable iff (SRST)
    (tick16 && st_ff.div == 13'h2 && !wr_fire) |=> !tick16 ##1 (tick16 || $past(wr_fire)))
    else $error("baud period wrong");
  a_rx_ninth_locked: assert property (@(posedge CLK) disable iff (SRST)
    (wr_fire && st_ff.aw_idx == IDX_DATA_HIGH && !frame_done) |=> $stable(st_ff.rx_ninth))
    else $error("write changed received ninth bit");
  a_tx_ninth_persist: assert property (@(posedge CLK) disable iff (SRST)
    !(wr_fire && st_ff.aw_idx == IDX_DATA_HIGH) |=> $stable(st_ff.tx_ninth))
    else $error("transmit ninth bit changed unasked");
  a_data_read_rx: assert property (@(posedge CLK) disable iff (SRST)
    (rd_fire && AXI_REQ.araddr == {3'h0, IDX_DATA_LOW, 2'h0}) |=>
    (AXI_RSP.rvalid && AXI_RSP.rdata[7:0] == $past(st_ff.rx_buf)))
    else $error("data read did not return receive buffer");
  a_ir_one_rest: assert property (@(posedge CLK) disable iff (SRST)
    (ir_on && tx_bit) |=> (TXD == $past(st_ff.tx_pol))) else $error("pulse on a one bit");
  a_nrz_stop_mark: assert property (@(posedge CLK) disable iff (SRST)
    (!ir_on && st_ff.tx_st == T_STOP) |=> (TXD == !$past(st_ff.tx_pol)))
    else $error("stop bit not at mark");
  a_frame_sets_full: assert property (@(posedge CLK) disable iff (SRST)
    (frame_done && !st_ff.rx_full) |=> st_ff.rx_full) else $error("frame lost");
  a_stretch_hold: assert property (@(posedge CLK) disable iff (SRST)
    (ir_on && (RXD ^ st_ff.rx_pol)) |=> (st_ff.stretch == STRETCH_LEN))
    else $error("pulse not stretched");

endmodule : serial_unit

// ### test/serial_peer.sv
// remote serial device: sends and receives one frame per task call.
// assumes bit time given in module clocks; its line rests at mark.
`timescale 1ns/1ps
module serial_peer (
  input wire logic CLK,
  input wire logic line_in,
  output logic line_out
);
  // line rests at mark so the receiver sees no false start
  initial line_out = 1'b1;

  // ------------------------------------------------------------
  // send: start, data lsb first, stop; ir gives centred pulses
  // ------------------------------------------------------------
  task automatic send(input logic [8:0] d, input bit nine, input int bc,
                      input bit ir, input logic pol);
    logic [10:0] fr;
    int n;
    fr = nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < bc; k++) begin
        @(posedge CLK);
        // a zero is one sixteenth of a bit, centred, at the active level
        if (ir) line_out <= (!fr[i] && k >= bc*15/32 && k < bc*17/32) ? ~pol : pol;
        else line_out <= fr[i];
      end
    end
  endtask : send

  // ------------------------------------------------------------
  // recv: waits for the start edge, samples each bit mid-way
  // ------------------------------------------------------------
  task automatic recv(output logic [8:0] d, output logic stop, input bit nine,
                      input int bc);
    int n;
    d = '0;
    n = nine ? 9 : 8;
    @(negedge line_in);
    repeat (bc / 2) @(posedge CLK);
    for (int i = 0; i < n; i++) begin
      repeat (bc) @(posedge CLK);
      d[i] = line_in;
    end
    repeat (bc) @(posedge CLK);
    stop = line_in;
  endtask : recv
endmodule : serial_peer

// ### test/serial_unit_tb.sv
// testbench for the serial unit: bus master tasks, line checks via the peer.
// assumes a 125 MHz clock and small divisors so frames stay short.
`timescale 1ns/1ps
module serial_unit_tb
  import serial_pkg::*;
;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  axi_req_t req = '0;
  axi_rsp_t rsp;
  logic rxd;
  logic txd;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #4 CLK = ~CLK;

  serial_unit DUT (.CLK(CLK), .SRST(SRST), .AXI_REQ(req), .AXI_RSP(rsp), .RXD(rxd),
                   .TXD(txd));
  serial_peer peer (.CLK(CLK), .line_in(txd), .line_out(rxd));

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // hang guard, sized well above the longest infrared run
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // register bus master
  // ------------------------------------------------------------
  function automatic logic [7:0] ad(input logic [2:0] i);
    return {3'h0, i, 2'h0};
  endfunction : ad

  function automatic int pulse_clk(input int div, input int p);
    int wt[4] = '{1, 2, 6, 8};
    return div * 16 * wt[p] / 32;
  endfunction : pulse_clk

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 1;
    w = 1;
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge CLK);
      aw = aw && rsp.awready !== 1'b1;
      w = w && rsp.wready !== 1'b1;
      req.awvalid <= aw;
      req.wvalid <= w;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge CLK);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar;
    ar = 1;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge CLK);
      ar = ar && rsp.arready !== 1'b1;
      req.arvalid <= ar;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge CLK);
  endtask : rd

  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, RESP_OKAY);
  endtask : w8

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, e);
  endtask : rchk

  // polls receive-full; the hang guard bounds the wait
  task automatic rx_wait();
    logic [31:0] d;
    logic [1:0] r;
    d = '0;
    while (d[0] !== 1'b1) rd(ad(IDX_STATUS_ONE), d, r);
  endtask : rx_wait

  task automatic set_div(input logic [12:0] v);
    w8(ad(IDX_BAUD_HIGH), {3'h0, v[12:8]});
    w8(ad(IDX_BAUD_LOW), v[7:0]);
  endtask : set_div

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [8:0] got;
    logic stop;
    logic [7:0] td;
    logic [7:0] rv;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    int w;
    n = $urandom(32020);
    repeat (16) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    // unmapped word answers with an error and zero data
    rd(8'h0c, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(8'h0c, 8'h55, r);
    chk(r, RESP_SLVERR);
    // divisor zero holds the line; the frame leaves once a divisor is set
    w8(ad(IDX_DATA_LOW), 8'ha5);
    repeat (300) begin
      @(posedge CLK);
      chk(txd, 1'b1);
    end
    fork
      peer.recv(got, stop, 0, 32);
      set_div(13'h0002);
    join
    chk(got, 9'h0a5);
    chk(stop, 1'b1);
    // both directions at once with random bytes
    for (int i = 0; i < 3; i++) begin
      td = 8'($urandom);
      rv = 8'($urandom);
      fork
        peer.send({1'b0, rv}, 0, 32, 0, 1'b0);
        peer.recv(got, stop, 0, 32);
        w8(ad(IDX_DATA_LOW), td);
      join
      chk(got, {1'b0, td});
      rx_wait();
      rchk(ad(IDX_DATA_LOW), 32'hff, {24'h0, rv});
    end
    // even then odd parity take the top data bit
    for (int p = 0; p < 2; p++) begin
      w8(ad(IDX_CONTROL), {5'h0, p[0], 2'h2});
      fork
        peer.recv(got, stop, 0, 32);
        w8(ad(IDX_DATA_LOW), 8'h07);
      join
      chk(got, {1'b0, ~p[0], 7'h07});
    end
    // nine-bit receive, then a write that tries to alter the received bit
    w8(ad(IDX_CONTROL), 8'h01);
    peer.send(9'h13c, 1, 32, 0, 1'b0);
    rx_wait();
    // full, transmit empty, no parity or framing error
    rchk(ad(IDX_STATUS_ONE), 32'hf, 32'h3);
    rchk(ad(IDX_DATA_HIGH), 32'h80, 32'h80);
    rchk(ad(IDX_DATA_LOW), 32'hff, 32'h3c);
    w8(ad(IDX_DATA_HIGH), 8'h40);
    rchk(ad(IDX_DATA_HIGH), 32'h80, 32'h80);
    // ninth bit reused until rewritten
    for (int i = 0; i < 3; i++) begin
      if (i == 2) w8(ad(IDX_DATA_HIGH), 8'h80);
      td = 8'($urandom);
      fork
        peer.recv(got, stop, 1, 32);
        w8(ad(IDX_DATA_LOW), td);
      join
      chk(got, {i != 2, td});
    end
    // infrared enable has no effect at a rate above its range
    w8(ad(IDX_CONTROL), 8'h08);
    fork
      peer.recv(got, stop, 0, 32);
      w8(ad(IDX_DATA_LOW), 8'h3c);
    join
    chk(got, 9'h03c);
    // infrared transmit: every width, both polarities
    w8(ad(IDX_CONTROL), 8'h00);
    set_div(13'd67);
    for (int pw = 0; pw < 4; pw++) begin
      w8(ad(IDX_STATUS_TWO), {3'h0, pw[0], 1'b1, 3'h0});
      w8(ad(IDX_CONTROL), {2'h0, pw[1:0], 4'h8});
      w8(ad(IDX_DATA_LOW), 8'hff);
      n = 0;
      while (txd !== ~pw[0]) @(posedge CLK);
      while (txd === ~pw[0]) begin
        @(posedge CLK);
        n++;
      end
      // a 1/32 width is not a whole count of clocks, so allow slack
      w = pulse_clk(67, pw);
      if (n >= w - 2 && n <= w + 2) n = w;
      chk(n, w);
      repeat (11 * 1072) @(posedge CLK);
    end
    // drop whatever the mode switch let in, then decode low pulses
    rd(ad(IDX_STATUS_ONE), d, r);
    rd(ad(IDX_DATA_LOW), d, r);
    peer.send(9'h05a, 0, 1072, 1, 1'b1);
    rx_wait();
    rchk(ad(IDX_DATA_LOW), 32'hff, 32'h5a);
    end_sim();
  end
endmodule : serial_unit_tb
